// File: udp_usart_map.svh
`ifndef UDP_USART_MAP_SVH
`define UDP_USART_MAP_SVH

// Register byte addresses
`define UDP_ADDR_DATA 12'h000
`define UDP_ADDR_STAT 12'h004
`define UDP_ADDR_CTRL 12'h008
`define UDP_ADDR_FRAME 12'h00c
`define UDP_ADDR_BAUD 12'h010

// Status register A bit positions
`define UDP_SA_RX_DONE 7
`define UDP_SA_TX_DONE 6
`define UDP_SA_TX_EMPTY 5
`define UDP_SA_DBL 1

// Control register B bit positions
`define UDP_CB_TX_DONE_IE 6
`define UDP_CB_EMPTY_IE 5
`define UDP_CB_RX_EN 4
`define UDP_CB_TX_EN 3
`define UDP_CB_SIZE_HI 2
`define UDP_CB_RX_NINTH 1
`define UDP_CB_TX_NINTH 0

// Frame config register bit positions
`define UDP_FC_SYNC 6
`define UDP_FC_PAR_EN 5
`define UDP_FC_PAR_ODD 4
`define UDP_FC_STOP2 3
`define UDP_FC_SIZE_MSB 2
`define UDP_FC_SIZE_LSB 1

// Reset values
`define UDP_RST_CTRL 8'h00
`define UDP_RST_FRAME 8'h06
`define UDP_RST_BAUD 12'h000

// Character size codes and lengths
`define UDP_SIZE_5 3'h0
`define UDP_SIZE_6 3'h1
`define UDP_SIZE_7 3'h2
`define UDP_SIZE_9 3'h7
`define UDP_LEN_5 4'h5
`define UDP_LEN_6 4'h6
`define UDP_LEN_7 4'h7
`define UDP_LEN_8 4'h8
`define UDP_LEN_9 4'h9

// Oversampling: last phase index per bit, and mid-bit index
`define UDP_OVS_LAST_N 4'hf
`define UDP_OVS_LAST_D 4'h7
`define UDP_OVS_MID_N 4'h7
`define UDP_OVS_MID_D 4'h3

`endif

// File: udp_pkg.sv
package udp_pkg;

  typedef enum logic [1:0] {
    UDP_TX_IDLE = 2'b01,
    UDP_TX_BUSY = 2'b10
  } udp_tx_state_t;

  typedef enum logic [2:0] {
    UDP_RX_IDLE  = 3'b001,
    UDP_RX_START = 3'b010,
    UDP_RX_DATA  = 3'b100
  } udp_rx_state_t;

endpackage

// File: udp_usart.sv
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ps
`include "udp_usart_map.svh"

// Functional notes
// - Transmit enable makes the block drive the serial output pin.
// - Sync mode: transmitter shifts on the sync clock pin.
// - Writing the data register loads the transmit buffer and starts sending.
// - Buffer moves to shifter when idle or right after last stop bit.
// - Shifter sends a whole frame at baud divider or sync clock rate.
// - Unused upper data bits are ignored for short characters.
// - Nine-bit size sends the stored ninth bit as data bit eight.
// - Buffer-empty flag clears on data write, sets when moved to shifter.
// - Buffer-empty request is a level while enabled and buffer empty.
// - Complete flag sets when frame done and nothing waits in buffer.
// - Complete flag clears on request service or write of one.
// - Complete request raised while its enable and the flag are set.
// - Parity bit goes after last data bit, before first stop bit.
// - Transmit disable waits until buffer and shifter empty, then releases pin.
// - Receive enable makes the block own the serial input pin.
// - Sync mode: receiver samples on the sync clock pin.
// - Valid start bit starts reception; bits sampled until first stop.
// - Second stop bit is ignored by the receiver.
// - Completed frame moves from receive shifter into receive buffer.
// - Short characters read back with upper bits zero.
// - Frame is start low, data LSB first, parity, stop high; idle high.
// - Parity is xor of data bits, inverted for odd parity.
// - Divider is 16 or 8 times divisor plus one; 8 samples when doubled.
// - Receive complete flag shows unread data; cleared when receiver off.
module udp_usart
  import udp_pkg::*;
(
  input wire logic sys_clk, // System clock, 25 MHz
  input wire logic arst_n, // Async reset, active low
  input wire logic psel, // APB select
  input wire logic penable, // APB access phase
  input wire logic pwrite, // APB direction
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  output logic txd_out, // Serial output level
  output logic txd_oe, // Serial output pin owned
  input wire logic rxd_in, // Serial input level
  output logic rxd_owned, // Serial input pin owned
  input wire logic xck_in, // Sync clock pin input
  input wire logic txc_irq_ack, // Complete request serviced
  output logic irq_buf_empty, // Buffer-empty request, level
  output logic irq_tx_done // Complete request, level
);

  // Software-visible configuration
  logic [7:0] ctrl_b;
  logic [7:0] frame_cfg;
  logic [11:0] baud_div;
  logic double_speed_bit;

  // Transmit path
  udp_tx_state_t tx_state;
  udp_tx_state_t next_tx_state;
  logic [8:0] tx_buf;
  logic tx_buf_full;
  logic [12:0] tx_shift;
  logic [3:0] tx_left;
  logic [3:0] tx_phase;
  logic txc_flag;

  // Receive path
  udp_rx_state_t rx_state;
  udp_rx_state_t next_rx_state;
  logic [3:0] rx_phase;
  logic [3:0] rx_idx;
  logic [8:0] rx_sh;
  logic [8:0] rx_buf;
  logic rx_full;

  // Baud divider and sync clock edge detect
  logic [11:0] baud_cnt;
  logic xck_s1;
  logic xck_s2;
  logic xck_s3;

  // APB decode
  wire setup = psel & ~penable;
  wire acc_done = psel & penable & pready;
  wire wr = acc_done & pwrite;
  wire rd = acc_done & ~pwrite;
  wire sel_data = (paddr == `UDP_ADDR_DATA);
  wire sel_stat = (paddr == `UDP_ADDR_STAT);
  wire sel_ctrl = (paddr == `UDP_ADDR_CTRL);
  wire sel_frame = (paddr == `UDP_ADDR_FRAME);
  wire sel_baud = (paddr == `UDP_ADDR_BAUD);
  wire mapped = sel_data | sel_stat | sel_ctrl | sel_frame | sel_baud;
  wire wr_data = wr & sel_data;
  wire rd_data = rd & sel_data;
  wire wr_stat = wr & sel_stat;

  // Configuration fields
  wire transmit_enable_bit = ctrl_b[`UDP_CB_TX_EN];
  wire receive_enable_bit = ctrl_b[`UDP_CB_RX_EN];
  wire buffer_empty_irq_enable = ctrl_b[`UDP_CB_EMPTY_IE];
  wire transmit_complete_irq_enable = ctrl_b[`UDP_CB_TX_DONE_IE];
  wire transmit_ninth_bit = ctrl_b[`UDP_CB_TX_NINTH];
  wire sync_mode = frame_cfg[`UDP_FC_SYNC];
  wire parity_enable_bit = frame_cfg[`UDP_FC_PAR_EN];
  wire parity_odd_select = frame_cfg[`UDP_FC_PAR_ODD];
  wire stop_bits_select = frame_cfg[`UDP_FC_STOP2];
  wire [2:0] character_size_field = {ctrl_b[`UDP_CB_SIZE_HI],
    frame_cfg[`UDP_FC_SIZE_MSB:`UDP_FC_SIZE_LSB]};

  // Data length; reserved size codes fall back to eight bits
  wire [3:0] char_len =
    (character_size_field == `UDP_SIZE_5) ? `UDP_LEN_5 :
    (character_size_field == `UDP_SIZE_6) ? `UDP_LEN_6 :
    (character_size_field == `UDP_SIZE_7) ? `UDP_LEN_7 :
    (character_size_field == `UDP_SIZE_9) ? `UDP_LEN_9 : `UDP_LEN_8;

  // Oversampling window: 16 phases per bit, 8 when doubled
  wire [3:0] bit_last = double_speed_bit ? `UDP_OVS_LAST_D
                                         : `UDP_OVS_LAST_N;
  wire [3:0] bit_mid = double_speed_bit ? `UDP_OVS_MID_D
                                        : `UDP_OVS_MID_N;
  wire baud_tick = (baud_cnt == `UDP_RST_BAUD);

  // Only synchronised stages feed the edge detector
  wire xck_rise = xck_s2 & ~xck_s3;
  wire xck_fall = ~xck_s2 & xck_s3;

  // Frame assembly from the buffer
  logic [11:0] tx_data_m;
  logic [12:0] frame_next;
  wire tx_par = (^tx_data_m) ^ parity_odd_select;
  wire [3:0] stop_cnt = stop_bits_select ? 4'h2 : 4'h1;
  wire [3:0] tx_frame_len = 4'h1 + char_len + {3'h0, parity_enable_bit}
                          + stop_cnt;

  assign frame_next[0] = 1'b0; // Start bit low
  genvar g;
  generate
    for (g = 0; g < 12; g = g + 1) begin : g_frame
      if (g < 9) begin : g_dat
        // Bits above the character size are dropped
        assign tx_data_m[g] = (4'(g) < char_len) & tx_buf[g];
      end else begin : g_pad
        assign tx_data_m[g] = 1'b0;
      end
      // Data LSB first, then parity, then stop ones
      assign frame_next[g + 1] = (4'(g) < char_len) ? tx_data_m[g] :
        (parity_enable_bit && 4'(g) == char_len) ? tx_par : 1'b1;
    end
  endgenerate

  // Transmit bit timing: divider phases or sync clock edges
  wire tx_strobe = sync_mode ? xck_rise
                 : (baud_tick && tx_phase == bit_last);
  wire tx_busy = (tx_state == UDP_TX_BUSY);
  wire tx_frame_end = tx_busy & tx_strobe & (tx_left == 4'h1);
  wire tx_load = tx_buf_full & (~tx_busy | tx_frame_end);
  // Pin stays owned until buffer and shifter drain
  wire next_txd_oe = transmit_enable_bit | tx_busy | tx_buf_full
                   | wr_data;

  // Receive bit timing and frame end
  wire rx_sample = sync_mode ? xck_fall
                 : (baud_tick && rx_phase == bit_last);
  wire [3:0] rx_stop_idx = char_len + {3'h0, parity_enable_bit};
  wire rx_in_data = (rx_state == UDP_RX_DATA);
  // Only the first stop bit is sampled
  wire rx_done = rx_in_data & rx_sample & (rx_idx == rx_stop_idx);
  // Align shifted data to bit 0; upper bits come out zero
  wire [8:0] rx_aligned = rx_sh >> (4'h9 - char_len);

  // Read mux
  wire [7:0] stat_rd = {rx_full, txc_flag, ~tx_buf_full, 3'h0,
                        double_speed_bit, 1'b0};
  wire [7:0] ctrl_rd = {ctrl_b[7:2], rx_buf[8], ctrl_b[0]};
  wire [31:0] rd_word =
    sel_data ? {23'h0, rx_buf} & 32'h0000_00ff :
    sel_stat ? {24'h0, stat_rd} :
    sel_ctrl ? {24'h0, ctrl_rd} :
    sel_frame ? {24'h0, frame_cfg} :
    sel_baud ? {20'h0, baud_div} : 32'h0;

  // APB slave: no wait state; every output is registered from the setup phase
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup & ~mapped;
      prdata <= setup ? rd_word : 32'h0;
    end
  end

  // Configuration registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_b <= `UDP_RST_CTRL;
      frame_cfg <= `UDP_RST_FRAME;
      baud_div <= `UDP_RST_BAUD;
      double_speed_bit <= 1'b0;
    end else begin
      if (wr & sel_ctrl)
        ctrl_b <= pwdata[7:0];
      if (wr & sel_frame)
        frame_cfg <= pwdata[7:0];
      if (wr & sel_baud)
        baud_div <= pwdata[11:0];
      if (wr_stat)
        double_speed_bit <= pwdata[`UDP_SA_DBL];
    end
  end

  // Baud divider: one tick per divisor+1 clocks
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      baud_cnt <= `UDP_RST_BAUD;
    else
      baud_cnt <= baud_tick ? baud_div : baud_cnt - 12'h1;
  end

  // Sync clock pin synchroniser; first stage read only by second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      xck_s1 <= 1'b0;
      xck_s2 <= 1'b0;
      xck_s3 <= 1'b0;
    end else begin
      xck_s1 <= xck_in;
      xck_s2 <= xck_s1;
      xck_s3 <= xck_s2;
    end
  end

  // Transmit state
  always_comb begin
    case (tx_state)
      UDP_TX_IDLE: next_tx_state = tx_load ? UDP_TX_BUSY : UDP_TX_IDLE;
      UDP_TX_BUSY: next_tx_state = (tx_frame_end && !tx_load)
                                   ? UDP_TX_IDLE : UDP_TX_BUSY;
      default: next_tx_state = UDP_TX_IDLE;
    endcase
  end

  // Transmit buffer; a write racing a load refills it
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_buf <= 9'h0;
      tx_buf_full <= 1'b0; // Empty after reset
    end else begin
      if (wr_data)
        tx_buf <= {transmit_ninth_bit, pwdata[7:0]};
      tx_buf_full <= wr_data | (tx_buf_full & ~tx_load);
    end
  end

  // Shift register and line driver
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_state <= UDP_TX_IDLE;
      tx_shift <= 13'h1fff;
      tx_left <= 4'h0;
      tx_phase <= 4'h0;
      txd_out <= 1'b1;
      txd_oe <= 1'b0;
    end else begin
      tx_state <= next_tx_state;
      txd_oe <= next_txd_oe;
      if (tx_load || (baud_tick && tx_phase == bit_last))
        tx_phase <= 4'h0;
      else if (baud_tick)
        tx_phase <= tx_phase + 4'h1;
      if (tx_load) begin
        tx_shift <= frame_next;
        tx_left <= tx_frame_len;
        txd_out <= frame_next[0];
      end else if (tx_frame_end) begin
        txd_out <= 1'b1; // Idle high between frames
      end else if (tx_busy && tx_strobe) begin
        tx_shift <= {1'b1, tx_shift[12:1]};
        tx_left <= tx_left - 4'h1;
        txd_out <= tx_shift[1];
      end
    end
  end

  // Complete flag: set wins over both clears
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n)
      txc_flag <= 1'b0;
    else if (tx_frame_end && !tx_buf_full)
      txc_flag <= 1'b1;
    else if (txc_irq_ack || (wr_stat && pwdata[`UDP_SA_TX_DONE]))
      txc_flag <= 1'b0;
  end

  // Interrupt request levels
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_buf_empty <= 1'b0;
      irq_tx_done <= 1'b0;
    end else begin
      irq_buf_empty <= buffer_empty_irq_enable & ~tx_buf_full;
      irq_tx_done <= transmit_complete_irq_enable & txc_flag;
    end
  end

  // Receive state; disabling the receiver aborts at once
  always_comb begin
    case (rx_state)
      UDP_RX_IDLE:
        if (!receive_enable_bit || rxd_in)
          next_rx_state = UDP_RX_IDLE;
        else if (sync_mode)
          next_rx_state = xck_fall ? UDP_RX_DATA : UDP_RX_IDLE;
        else
          next_rx_state = UDP_RX_START;
      UDP_RX_START:
        // Start is valid only if still low at mid-bit
        if (!receive_enable_bit || (baud_tick && rx_phase == bit_mid
            && rxd_in))
          next_rx_state = UDP_RX_IDLE;
        else if (baud_tick && rx_phase == bit_mid)
          next_rx_state = UDP_RX_DATA;
        else
          next_rx_state = UDP_RX_START;
      UDP_RX_DATA:
        next_rx_state = (!receive_enable_bit || rx_done)
                        ? UDP_RX_IDLE : UDP_RX_DATA;
      default: next_rx_state = UDP_RX_IDLE;
    endcase
  end

  // Receive shifter: phase counts from mid start bit
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_state <= UDP_RX_IDLE;
      rx_phase <= 4'h0;
      rx_idx <= 4'h0;
      rx_sh <= 9'h0;
      rxd_owned <= 1'b0;
    end else begin
      rx_state <= next_rx_state;
      rxd_owned <= receive_enable_bit;
      if (next_rx_state != rx_state || rx_sample)
        rx_phase <= 4'h0;
      else if (baud_tick)
        rx_phase <= rx_phase + 4'h1;
      if (!rx_in_data) begin
        rx_idx <= 4'h0;
        rx_sh <= 9'h0;
      end else if (rx_sample) begin
        rx_idx <= rx_idx + 4'h1;
        if (rx_idx < char_len)
          rx_sh <= {rxd_in, rx_sh[8:1]};
      end
    end
  end

  // Receive buffer; new frame wins over a read
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_buf <= 9'h0;
      rx_full <= 1'b0;
    end else begin
      if (rx_done)
        rx_buf <= rx_aligned;
      if (!receive_enable_bit)
        rx_full <= 1'b0; // Flushed when off
      else if (rx_done)
        rx_full <= 1'b1;
      else if (rd_data)
        rx_full <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  sequence s_load_start;
    tx_load ##1 (tx_busy && !txd_out);
  endsequence

  a_apb_ready_pulse: assert property (setup |=> pready ##1 !pready)
    else $error("pready not a single cycle after setup");
  a_tx_load_start: assert property (tx_load |-> s_load_start)
    else $error("load did not start a low start bit");
  a_tx_idle_high: assert property (!tx_busy |-> txd_out)
    else $error("serial output not high while idle");
  a_buf_write_full: assert property (wr_data |=> tx_buf_full)
    else $error("data write did not fill buffer");
  a_txc_frame_end: assert property (
    tx_frame_end && !tx_buf_full |=> txc_flag)
    else $error("complete flag missing after frame");
  a_txc_ack_clear: assert property (
    txc_irq_ack && !tx_frame_end |=> !txc_flag)
    else $error("complete flag not cleared by service");
  a_pin_release: assert property (
    !transmit_enable_bit && !tx_busy && !tx_buf_full && !wr_data
    |=> !txd_oe)
    else $error("serial output pin not released");
  a_empty_irq_level: assert property (
    buffer_empty_irq_enable && !tx_buf_full |=> irq_buf_empty)
    else $error("buffer-empty request missing");
  a_rx_move_buf: assert property (
    rx_done && receive_enable_bit |=> rx_full)
    else $error("received frame not moved to buffer");
  a_rx_flush_off: assert property (
    !receive_enable_bit |=> !rx_full ##1 !rx_full)
    else $error("receive flag set while disabled");

endmodule // udp_usart

// File: udp_remote.sv
`timescale 1ns/1ps
// Far-end serial transceiver; bit timing is set by the bench
module udp_remote (
  input wire logic sys_clk, // System clock
  input wire logic txd_out, // Line driven by the block
  output logic rxd_in // Line into the block
);
  int ticks = 16; // Clocks per bit
  int nbits = 9; // Bits captured after start, first stop included
  logic [11:0] q[$]; // Captured frames, first bit after start in bit 0

  // Line idles high between frames
  initial rxd_in = 1'b1;

  // Mid-bit sampling; wrong bit timing garbles the captured frame
  always begin : cap
    logic [11:0] f;
    f = 12'h000;
    @(negedge txd_out);
    repeat (ticks / 2) @(posedge sys_clk);
    for (int i = 0; i < nbits; i++) begin
      repeat (ticks) @(posedge sys_clk);
      f[i] = txd_out;
    end
    q.push_back(f);
  end

  // Low start bit, then n bits first-bit-first, then back to idle
  task automatic send(input logic [11:0] bits, input int n);
    rxd_in <= 1'b0;
    repeat (ticks) @(posedge sys_clk);
    for (int i = 0; i < n; i++) begin
      rxd_in <= bits[i];
      repeat (ticks) @(posedge sys_clk);
    end
    rxd_in <= 1'b1;
  endtask
endmodule // udp_remote

// File: udp_usart_tb_top.sv
`timescale 1ns/1ps
`include "udp_usart_map.svh"
// Bench: APB register calls with a far-end serial model
module udp_usart_tb_top;
  typedef struct {
    logic [7:0] fr, ct;
    logic [8:0] d;
    int len;
    logic pe, odd, dbl;
    logic [11:0] bd;
  } udp_tc_t;
  logic sys_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
  logic pwrite = 1'b0, xck_in = 1'b0, txc_irq_ack = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, txd_out, txd_oe, rxd_in, rxd_owned;
  logic irq_buf_empty, irq_tx_done;
  int n_fail = 0, checked = 0, cyc = 0;
  udp_tc_t tc[7];

  always #20 sys_clk = ~sys_clk;

  udp_usart udp_usart_i (.sys_clk, .arst_n, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .txd_out, .txd_oe,
    .rxd_in, .rxd_owned, .xck_in, .txc_irq_ack, .irq_buf_empty,
    .irq_tx_done);
  udp_remote udp_remote_i (.sys_clk, .txd_out, .rxd_in);

  task automatic check(input string what, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  // One transfer; request held until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic rchk(input string what, input logic [11:0] a,
                      input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(what, rd, exp);
  endtask

  // Wait for a captured frame, then let its stop bit run out
  task automatic wait_frame(input int t);
    while (udp_remote_i.q.size() == 0) @(posedge sys_clk);
    repeat (t) @(posedge sys_clk);
  endtask

  // Bits after start: data first-bit-first, parity, first stop
  function automatic logic [11:0] frame(logic [8:0] d, int len,
                                        logic pe, odd);
    logic [11:0] f;
    logic p;
    f = 12'h000;
    p = odd;
    for (int i = 0; i < len; i++) begin
      f[i] = d[i];
      p ^= d[i];
    end
    if (pe) f[len] = p;
    f[len + pe] = 1'b1;
    return f;
  endfunction

  task automatic end_of_test();
    $display("comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Hang guard: the tests need well under this many cycles
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      end_of_test();
    end
  end

  initial begin
    int t;
    logic [11:0] ef;
    tc = '{'{8'h0e, 8'h08, 9'h0a5, 8, 1'b0, 1'b0, 1'b0, 12'h000},
           '{8'h24, 8'h08, 9'h0ff, 7, 1'b1, 1'b0, 1'b0, 12'h000},
           '{8'h30, 8'h08, 9'h03b, 5, 1'b1, 1'b1, 1'b0, 12'h000},
           '{8'h22, 8'h08, 9'h02a, 6, 1'b1, 1'b0, 1'b0, 12'h000},
           '{8'h06, 8'h0d, 9'h15a, 9, 1'b0, 1'b0, 1'b0, 12'h000},
           '{8'h06, 8'h08, 9'h096, 8, 1'b0, 1'b0, 1'b0, 12'h001},
           '{8'h06, 8'h08, 9'h069, 8, 1'b0, 1'b0, 1'b1, 12'h000}};
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    // Reset state and an unmapped access
    rchk("status", `UDP_ADDR_STAT, 32'h20);
    rchk("ctrl", `UDP_ADDR_CTRL, 32'h0);
    rchk("frame cfg", `UDP_ADDR_FRAME, 32'h6);
    rchk("baud", `UDP_ADDR_BAUD, 32'h0);
    check("idle line", {txd_oe, txd_out}, 2'b01);
    rchk("unmapped", 12'h014, 32'h0);
    check("slave error", err, 1'b1);
    $display("test reset done");
    // Two writes back to back: the second waits in the buffer
    apb(1'b1, `UDP_ADDR_CTRL, 32'h68);
    repeat (2) @(posedge sys_clk);
    check("pin owned", txd_oe, 1'b1);
    check("empty irq", irq_buf_empty, 1'b1);
    apb(1'b1, `UDP_ADDR_DATA, 32'ha5);
    apb(1'b1, `UDP_ADDR_DATA, 32'h3c);
    rchk("buffer held", `UDP_ADDR_STAT, 32'h0);
    check("empty irq off", irq_buf_empty, 1'b0);
    wait_frame(16);
    check("frame a", udp_remote_i.q.pop_front(), 12'h1a5);
    rchk("second loaded", `UDP_ADDR_STAT, 32'h20);
    check("empty irq back", irq_buf_empty, 1'b1);
    wait_frame(16);
    check("frame b", udp_remote_i.q.pop_front(), 12'h13c);
    rchk("all sent", `UDP_ADDR_STAT, 32'h60);
    check("done irq", irq_tx_done, 1'b1);
    apb(1'b1, `UDP_ADDR_STAT, 32'h40);
    rchk("one clears", `UDP_ADDR_STAT, 32'h20);
    check("done irq off", irq_tx_done, 1'b0);
    $display("test back to back done");
    // Every size and parity kind at three bit rates, cleared by service
    foreach (tc[i]) begin
      t = (tc[i].dbl ? 8 : 16) * (tc[i].bd + 1);
      udp_remote_i.ticks = t;
      udp_remote_i.nbits = tc[i].len + tc[i].pe + 1;
      apb(1'b1, `UDP_ADDR_BAUD, {20'h0, tc[i].bd});
      apb(1'b1, `UDP_ADDR_STAT, {30'h0, tc[i].dbl, 1'b0});
      apb(1'b1, `UDP_ADDR_FRAME, {24'h0, tc[i].fr});
      apb(1'b1, `UDP_ADDR_CTRL, {24'h0, tc[i].ct});
      apb(1'b1, `UDP_ADDR_DATA, {24'h0, tc[i].d[7:0]});
      wait_frame(2 * t);
      ef = frame(tc[i].d, tc[i].len, tc[i].pe, tc[i].odd);
      check("frame", udp_remote_i.q.pop_front(), ef);
      rchk("done", `UDP_ADDR_STAT, {24'h0, 6'h18, tc[i].dbl, 1'b0});
      txc_irq_ack <= 1'b1;
      @(posedge sys_clk);
      txc_irq_ack <= 1'b0;
      rchk("serviced", `UDP_ADDR_STAT, {24'h0, 6'h08, tc[i].dbl, 1'b0});
    end
    $display("test formats done");
    // Disable mid-frame: pin stays owned until the frame ends
    apb(1'b1, `UDP_ADDR_STAT, 32'h0);
    udp_remote_i.ticks = 16;
    udp_remote_i.nbits = 9;
    apb(1'b1, `UDP_ADDR_DATA, 32'h5e);
    apb(1'b1, `UDP_ADDR_CTRL, 32'h00);
    repeat (16) @(posedge sys_clk);
    check("pin kept", txd_oe, 1'b1);
    wait_frame(24);
    check("pin freed", txd_oe, 1'b0);
    check("last frame", udp_remote_i.q.pop_front(), 12'h15e);
    apb(1'b1, `UDP_ADDR_STAT, 32'h40);
    $display("test disable done");
    // Sync mode: the sync clock only runs during the frame
    apb(1'b1, `UDP_ADDR_FRAME, 32'h46);
    apb(1'b1, `UDP_ADDR_CTRL, 32'h08);
    apb(1'b1, `UDP_ADDR_DATA, 32'h96);
    // First rise lands so that the start bit lasts 16 clocks
    repeat (13) @(posedge sys_clk);
    repeat (10) begin
      xck_in <= 1'b1;
      repeat (8) @(posedge sys_clk);
      xck_in <= 1'b0;
      repeat (8) @(posedge sys_clk);
    end
    check("sync frame", udp_remote_i.q.pop_front(), 12'h196);
    rchk("sync done", `UDP_ADDR_STAT, 32'h60);
    apb(1'b1, `UDP_ADDR_STAT, 32'h40);
    $display("test sync done");
    // Receive 8 bits with two stops, 5 bits, then flush by disable
    apb(1'b1, `UDP_ADDR_FRAME, 32'h6);
    apb(1'b1, `UDP_ADDR_CTRL, 32'h10);
    repeat (2) @(posedge sys_clk);
    check("rx owned", rxd_owned, 1'b1);
    udp_remote_i.send(12'h3c3, 10);
    rchk("rx flag", `UDP_ADDR_STAT, 32'ha0);
    rchk("rx data", `UDP_ADDR_DATA, 32'hc3);
    rchk("rx read", `UDP_ADDR_STAT, 32'h20);
    apb(1'b1, `UDP_ADDR_FRAME, 32'h0);
    udp_remote_i.send(12'h075, 7);
    rchk("short data", `UDP_ADDR_DATA, 32'h15);
    udp_remote_i.send(12'h075, 7);
    apb(1'b1, `UDP_ADDR_CTRL, 32'h00);
    rchk("flushed", `UDP_ADDR_STAT, 32'h20);
    check("rx freed", rxd_owned, 1'b0);
    $display("test receive done");
    end_of_test();
  end
endmodule // udp_usart_tb_top
